// *** logic/flash_regs_pkg.sv ***
// Shared constants and types of the serial flash status and configuration bank
package flash_regs_pkg;
  // -------------------------------------------------------------------------
  // Clock and timing
  // -------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int CFG_WRITE_NS = 5000;
  localparam int CFG_TIMER_W = 11;
  localparam logic [CFG_TIMER_W-1:0] CFG_WRITE_CYCLES = CFG_TIMER_W'(CFG_WRITE_NS / CLK_PERIOD_NS);
  localparam int RESTART_LOW_NS = 1000;
  localparam logic [7:0] RESTART_LOW_CYCLES =
    8'((RESTART_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // -------------------------------------------------------------------------
  // Command codes
  // -------------------------------------------------------------------------
  localparam logic [7:0] OP_PERMIT_SET = 8'h06;
  localparam logic [7:0] OP_PERMIT_CLEAR = 8'h04;
  localparam logic [7:0] OP_READ_LOW = 8'h05;
  localparam logic [7:0] OP_READ_MID = 8'h35;
  localparam logic [7:0] OP_READ_HIGH = 8'h15;
  localparam logic [7:0] OP_CFG_WRITE_LO = 8'h01;
  localparam logic [7:0] OP_CFG_WRITE_HI = 8'h11;
  localparam logic [7:0] OP_EXT_READ = 8'hc8;
  localparam logic [7:0] OP_EXT_WRITE = 8'hc5;
  localparam logic [7:0] OP_FOUR_ENTER = 8'hb7;
  localparam logic [7:0] OP_FOUR_EXIT = 8'he9;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_GO = 8'h99;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_CHIP_WIPE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_WIPE_B = 8'hc7;
  // -------------------------------------------------------------------------
  // Status word layout, masks and latency figures
  // -------------------------------------------------------------------------
  localparam logic [23:0] NV_MASK = 24'hf333fc;
  localparam logic [23:0] NV_FACTORY = 24'h200000;
  localparam int BOOT_WIDTH_POS = 20;
  localparam logic [3:0] DUMMY_SHORT = 4'h6;
  localparam logic [3:0] DUMMY_MID = 4'h8;
  localparam logic [3:0] DUMMY_LONG = 4'ha;
  // Synchronised pin indices
  localparam int PIN_CS = 0;
  localparam int PIN_WP = 1;
  localparam int PIN_PR = 2;
  localparam int PIN_TOG = 3;
  localparam logic [3:0] PIN_IDLE = 4'h7;

  typedef struct packed {
    logic restart_sel;
    logic [1:0] output_strength;
    logic boot_addr_width;
    logic erase_fail_flag;
    logic program_fail_flag;
    logic [1:0] latency_sel;
    logic erase_paused_flag;
    logic reserved_s14;
    logic [1:0] secure_area_lock;
    logic addr_width_state;
    logic program_paused_flag;
    logic quad_pins_on;
    logic guard_mode_hi;
    logic guard_mode_lo;
    logic [4:0] area_guard;
    logic write_permit_latch;
    logic busy_flag;
  } status_word_type;

  typedef struct packed {
    status_word_type status;
    logic [7:0] ext;
  } link_view_type;
endpackage

// *** logic/flash_status_bank.sv ***
// Status, protection and configuration bank of a serial flash with its link front end
`timescale 1ns/10ps
// What this block does
// - Busy flag high during program, erase, word write
// - Permit latch clear refuses writes, programs, erases
// - Five area-guard bits written by word write
// - Area-guard bits change only when not hardware-locked
// - Guard mode 00: write whenever permit set
// - Guard mode 01: guard pin low locks word
// - Guard mode 10: locked until power cycle clears
// - Guard mode 11: word permanently locked
// - Quad bit turns guard and pause pins into data
// - Read-only bit shows three or four byte addressing
// - Security lock bits are one-time settable
// - Suspend sets erase or program paused flag
// - Resume, software reset, power cycle clear paused
// - Latency bits pick 6, 6, 8, 10 dummies
// - Program fail flag set on failure, cleared on resume
// - Erase fail flag set on failure, cleared on resume
// - Boot width bit picks start addressing mode
// - Strength bits pick 100, 75, 50, 25 percent
// - Select bit picks pause or restart pin role
// - Extension bit picks upper half in three-byte mode
// - Four-byte mode ignores the extension bit
// - Permit latch set and cleared by listed commands

// ---------------------------------------------------------------------------
// Link side: shifts bytes on the serial clock and returns read data
// ---------------------------------------------------------------------------
module flash_link_shifter (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic reset_n,
  input wire logic si,
  input wire flash_regs_pkg::link_view_type view,
  output logic byte_tog,
  output logic [7:0] byte_data,
  output logic so,
  output logic so_oe_n
);
  typedef struct packed {
    logic [2:0] bits;
    logic [6:0] shift;
    logic first_done;
    logic reading;
    logic [7:0] sel;
    logic [7:0] out_buf;
  } link_state_type;

  link_state_type q, d;
  logic [7:0] nxt;

  // Returns {is_read, byte} for a command code
  function automatic logic [8:0] read_pick(input logic [7:0] c,
                                           input flash_regs_pkg::link_view_type v);
    unique case (c)
      flash_regs_pkg::OP_READ_LOW: read_pick = {1'b1, v.status[7:0]};
      flash_regs_pkg::OP_READ_MID: read_pick = {1'b1, v.status[15:8]};
      flash_regs_pkg::OP_READ_HIGH: read_pick = {1'b1, v.status[23:16]};
      flash_regs_pkg::OP_EXT_READ: read_pick = {1'b1, v.ext};
      default: read_pick = 9'h000;
    endcase
  endfunction

  // Next frame state: shift in, pick read byte after the command byte
  always_comb begin
    d = q;
    nxt = {q.shift, si};
    d.shift = nxt[6:0];
    d.bits = q.bits + 3'h1;
    if (q.reading) begin
      d.out_buf = {q.out_buf[6:0], 1'b0};
    end
    if (q.bits == 3'h7) begin
      if (!q.first_done) begin
        d.first_done = 1'b1;
        d.sel = nxt;
        d.reading = read_pick(nxt, view) >> 8 != 9'h000;
      end
      if (d.reading) begin
        d.out_buf = 8'(read_pick(d.sel, view)); // Repeats the byte while clocked
      end
    end
  end

  // Frame state is cleared whenever the host deselects
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Completed bytes are handed over with a toggle that survives frames
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      byte_tog <= 1'b0;
      byte_data <= 8'h00;
    end else if (q.bits == 3'h7) begin
      byte_tog <= ~byte_tog;
      byte_data <= nxt;
    end
  end

  // Output bit launched on the falling edge, sampled by the host on the rising
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      so <= 1'b0;
      so_oe_n <= 1'b1;
    end else begin
      so <= q.out_buf[7];
      so_oe_n <= ~q.reading;
    end
  end
endmodule

// ---------------------------------------------------------------------------
// Register bank on the system clock
// ---------------------------------------------------------------------------
module flash_status_bank #(
  parameter logic [7:0] PAGE_WRITE_OPCODE = 8'h02,
  parameter logic [7:0] SMALL_WIPE_OPCODE = 8'h20,
  parameter logic [7:0] LARGE_WIPE_OPCODE = 8'hd8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  input wire logic wp_io_n,
  input wire logic pause_restart_io_n,
  input wire logic [23:0] nv_image,
  input wire logic engine_busy,
  input wire logic prog_fail,
  input wire logic erase_fail,
  output logic array_cmd_valid,
  output logic [7:0] array_cmd,
  output logic suspend_req,
  output logic resume_req,
  output logic nv_store_write,
  output logic [23:0] nv_store_data,
  output logic busy_flag,
  output logic write_permit_latch,
  output logic quad_pins_on,
  output logic pause_pin_on,
  output logic restart_pin_on,
  output logic [3:0] dummy_cycles,
  output logic [1:0] output_strength,
  output logic addr_four_byte,
  output logic upper_half_select,
  output logic [4:0] area_guard,
  output logic [1:0] secure_area_lock
);
  typedef struct packed {
    logic [3:0] sy0;
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic [3:0] flt;
    flash_regs_pkg::status_word_type st;
    logic [7:0] ext;
    flash_regs_pkg::link_view_type view;
    logic [1:0] nb;
    logic [7:0] cmd;
    logic [7:0] b1;
    logic [7:0] b2;
    logic reset_armed;
    logic [flash_regs_pkg::CFG_TIMER_W-1:0] cfg_timer;
    logic op_erase;
    logic [7:0] restart_cnt;
    logic cmd_valid;
    logic [7:0] cmd_out;
    logic susp;
    logic resm;
    logic nv_wr;
    logic [23:0] nv_data;
    logic [3:0] dummy;
    logic pause_on;
    logic restart_on;
    logic upper_half;
  } top_state_type;

  top_state_type q, d;
  logic byte_tog;
  logic [7:0] byte_data;
  logic cs_rise;
  logic byte_evt;
  logic soft_rst;
  logic [1:0] fr_nb;
  flash_regs_pkg::status_word_type wdata;
  flash_regs_pkg::status_word_type merged;

  // Whether the guard mode lets the word be written now
  function automatic logic guard_ok(input flash_regs_pkg::status_word_type s,
                                    input logic wp_level);
    unique case ({s.guard_mode_hi, s.guard_mode_lo})
      2'b00: guard_ok = 1'b1;
      2'b01: guard_ok = s.quad_pins_on | wp_level;
      2'b10: guard_ok = 1'b0;
      2'b11: guard_ok = 1'b0;
    endcase
  endfunction

  // Dummy cycles for the quad input/output read
  function automatic logic [3:0] dummy_count(input logic [1:0] sel);
    unique case (sel)
      2'b00: dummy_count = flash_regs_pkg::DUMMY_SHORT;
      2'b01: dummy_count = flash_regs_pkg::DUMMY_SHORT;
      2'b10: dummy_count = flash_regs_pkg::DUMMY_MID;
      2'b11: dummy_count = flash_regs_pkg::DUMMY_LONG;
    endcase
  endfunction

  flash_link_shifter link (
    .sclk(sclk),
    .cs_n(cs_n),
    .reset_n(reset_n),
    .si(si),
    .view(q.view),
    .byte_tog(byte_tog),
    .byte_data(byte_data),
    .so(so),
    .so_oe_n(so_oe_n)
  );

  // Next state of the whole bank
  always_comb begin
    d = q;
    cs_rise = 1'b0;
    byte_evt = 1'b0;
    soft_rst = 1'b0;
    fr_nb = 2'h0;
    wdata = q.st;
    merged = q.st;
    d.sy0 = {byte_tog, pause_restart_io_n, wp_io_n, cs_n};
    d.sy1 = q.sy0;
    d.sy2 = q.sy1;
    for (int i = 0; i < 4; i++) begin
      if (q.sy1[i] == q.sy2[i]) begin
        d.flt[i] = q.sy2[i];
      end
    end
    d.cmd_valid = 1'b0;
    d.susp = 1'b0;
    d.resm = 1'b0;
    d.nv_wr = 1'b0;
    if (!reset_n) begin
      // Power cycle: non-volatile bits from the store, lock-down mode released
      d = '0;
      d.sy0 = flash_regs_pkg::PIN_IDLE;
      d.sy1 = flash_regs_pkg::PIN_IDLE;
      d.sy2 = flash_regs_pkg::PIN_IDLE;
      d.flt = flash_regs_pkg::PIN_IDLE;
      d.st = nv_image & flash_regs_pkg::NV_MASK;
      if (d.st.guard_mode_hi && !d.st.guard_mode_lo) begin
        d.st.guard_mode_hi = 1'b0;
      end
      d.st.addr_width_state = nv_image[flash_regs_pkg::BOOT_WIDTH_POS];
    end else begin
      cs_rise = d.flt[flash_regs_pkg::PIN_CS] & ~q.flt[flash_regs_pkg::PIN_CS];
      byte_evt = d.flt[flash_regs_pkg::PIN_TOG] ^ q.flt[flash_regs_pkg::PIN_TOG];
      // Collect command and first two operand bytes of the frame
      if (byte_evt) begin
        unique case (q.nb)
          2'h0: d.cmd = byte_data;
          2'h1: d.b1 = byte_data;
          2'h2: d.b2 = byte_data;
          2'h3: d.b2 = q.b2;
        endcase
        if (q.nb != 2'h3) begin
          d.nb = q.nb + 2'h1;
        end
      end
      // Word write timer; the new non-volatile image is stored at its end
      if (q.cfg_timer != '0) begin
        d.cfg_timer = q.cfg_timer - 1'b1;
        if (q.cfg_timer == 1) begin
          d.nv_wr = 1'b1;
          d.nv_data = q.st & flash_regs_pkg::NV_MASK;
        end
      end
      // Commands execute when the host deselects
      if (cs_rise) begin
        fr_nb = d.nb;
        d.nb = 2'h0;
        d.reset_armed = 1'b0;
        if (fr_nb != 2'h0) begin
          unique case (d.cmd)
            flash_regs_pkg::OP_PERMIT_SET: begin
              if (!q.st.busy_flag) d.st.write_permit_latch = 1'b1;
            end
            flash_regs_pkg::OP_PERMIT_CLEAR: begin
              if (!q.st.busy_flag) d.st.write_permit_latch = 1'b0;
            end
            flash_regs_pkg::OP_CFG_WRITE_LO, flash_regs_pkg::OP_CFG_WRITE_HI: begin
              if (d.cmd == flash_regs_pkg::OP_CFG_WRITE_LO) begin
                wdata[7:0] = d.b1;
                if (fr_nb == 2'h3) wdata[15:8] = d.b2;
              end else begin
                wdata[23:16] = d.b1;
              end
              merged = (q.st & ~flash_regs_pkg::NV_MASK) | (wdata & flash_regs_pkg::NV_MASK);
              merged.secure_area_lock = merged.secure_area_lock | q.st.secure_area_lock;
              if (fr_nb >= 2'h2 && q.st.write_permit_latch && !q.st.busy_flag &&
                  guard_ok(q.st, q.flt[flash_regs_pkg::PIN_WP])) begin
                d.st = merged;
                d.st.write_permit_latch = 1'b0;
                d.cfg_timer = flash_regs_pkg::CFG_WRITE_CYCLES;
              end
            end
            flash_regs_pkg::OP_EXT_WRITE: begin
              if (fr_nb >= 2'h2 && !q.st.busy_flag) d.ext = {7'h00, d.b1[0]};
            end
            flash_regs_pkg::OP_FOUR_ENTER: d.st.addr_width_state = 1'b1;
            flash_regs_pkg::OP_FOUR_EXIT: d.st.addr_width_state = 1'b0;
            flash_regs_pkg::OP_RESET_ARM: d.reset_armed = 1'b1;
            flash_regs_pkg::OP_RESET_GO: soft_rst = q.reset_armed;
            flash_regs_pkg::OP_SUSPEND: begin
              if (engine_busy && !q.st.erase_paused_flag && !q.st.program_paused_flag) begin
                d.susp = 1'b1;
                if (q.op_erase) d.st.erase_paused_flag = 1'b1;
                else d.st.program_paused_flag = 1'b1;
              end
            end
            flash_regs_pkg::OP_RESUME: begin
              if (q.st.erase_paused_flag || q.st.program_paused_flag) begin
                d.resm = 1'b1;
                d.st.erase_paused_flag = 1'b0;
                d.st.program_paused_flag = 1'b0;
                if (q.st.erase_paused_flag) d.st.erase_fail_flag = 1'b0;
                if (q.st.program_paused_flag) d.st.program_fail_flag = 1'b0;
              end
            end
            default: begin
              // Array commands go to the engine only with the permit latch set
              if ((d.cmd == PAGE_WRITE_OPCODE || d.cmd == SMALL_WIPE_OPCODE ||
                   d.cmd == LARGE_WIPE_OPCODE || d.cmd == flash_regs_pkg::OP_CHIP_WIPE_A ||
                   d.cmd == flash_regs_pkg::OP_CHIP_WIPE_B) &&
                  q.st.write_permit_latch && !q.st.busy_flag) begin
                d.cmd_valid = 1'b1;
                d.cmd_out = d.cmd;
                d.op_erase = d.cmd != PAGE_WRITE_OPCODE;
                d.st.write_permit_latch = 1'b0;
              end
            end
          endcase
        end
      end
      // Restart pin held low long enough acts as a device reset
      if (q.restart_on && !q.flt[flash_regs_pkg::PIN_PR]) begin
        if (q.restart_cnt != flash_regs_pkg::RESTART_LOW_CYCLES) begin
          d.restart_cnt = q.restart_cnt + 8'h01;
        end
        if (q.restart_cnt == flash_regs_pkg::RESTART_LOW_CYCLES - 8'h01) begin
          soft_rst = 1'b1;
        end
      end else begin
        d.restart_cnt = 8'h00;
      end
      // Device reset: volatile bits back to power-on values
      if (soft_rst) begin
        d.st.write_permit_latch = 1'b0;
        d.st.erase_paused_flag = 1'b0;
        d.st.program_paused_flag = 1'b0;
        d.st.erase_fail_flag = 1'b0;
        d.st.program_fail_flag = 1'b0;
        d.st.addr_width_state = q.st.boot_addr_width;
        d.ext = 8'h00;
      end
      // Failure reports win over any clear in the same cycle
      if (prog_fail) d.st.program_fail_flag = 1'b1;
      if (erase_fail) d.st.erase_fail_flag = 1'b1;
    end
    // Derived outputs each cycle, and the read-back view frozen while a frame is open
    d.st.busy_flag = engine_busy | (d.cfg_timer != '0);
    d.dummy = dummy_count(d.st.latency_sel);
    d.pause_on = ~d.st.quad_pins_on & ~d.st.restart_sel;
    d.restart_on = ~d.st.quad_pins_on & d.st.restart_sel;
    d.upper_half = d.ext[0] & ~d.st.addr_width_state;
    if (d.flt[flash_regs_pkg::PIN_CS]) begin
      d.view = {d.st, d.ext};
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  // Outputs straight from the state register
  assign array_cmd_valid = q.cmd_valid;
  assign array_cmd = q.cmd_out;
  assign suspend_req = q.susp;
  assign resume_req = q.resm;
  assign nv_store_write = q.nv_wr;
  assign nv_store_data = q.nv_data;
  assign busy_flag = q.st.busy_flag;
  assign write_permit_latch = q.st.write_permit_latch;
  assign quad_pins_on = q.st.quad_pins_on;
  assign pause_pin_on = q.pause_on;
  assign restart_pin_on = q.restart_on;
  assign dummy_cycles = q.dummy;
  assign output_strength = q.st.output_strength;
  assign addr_four_byte = q.st.addr_width_state;
  assign upper_half_select = q.upper_half;
  assign area_guard = q.st.area_guard;
  assign secure_area_lock = q.st.secure_area_lock;

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  localparam logic [23:0] NV_MASK_L = flash_regs_pkg::NV_MASK;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  busy_follows_engine_a: assert property (engine_busy |=> busy_flag)
    else $error("busy flag low while engine busy");
  no_permit_refuse_a: assert property (cs_rise && !q.st.write_permit_latch |=>
    !array_cmd_valid && ((q.st & NV_MASK_L) == $past(q.st & NV_MASK_L)))
    else $error("command taken without permit latch");
  lockdown_hold_a: assert property (q.st.guard_mode_hi |=>
    (q.st & NV_MASK_L) == $past(q.st & NV_MASK_L))
    else $error("locked word changed");
  hw_lock_hold_a: assert property (q.st.guard_mode_lo && !q.st.guard_mode_hi &&
    !q.st.quad_pins_on && !q.flt[flash_regs_pkg::PIN_WP] |=>
    q.st.area_guard == $past(q.st.area_guard))
    else $error("area guard changed under pin lock");
  otp_sticky_a: assert property (q.st.secure_area_lock[1] |=> q.st.secure_area_lock[1])
    else $error("security lock bit cleared");
  resume_clears_a: assert property (cs_rise && d.cmd == flash_regs_pkg::OP_RESUME &&
    d.nb == 2'h0 && q.nb != 2'h0 |=> !q.st.erase_paused_flag && !q.st.program_paused_flag)
    else $error("paused flag survived resume");
  dummy_long_a: assert property (q.st.latency_sel == 2'b11 |-> dummy_cycles == 4'ha)
    else $error("wrong dummy count");
  prog_fail_set_a: assert property (prog_fail |=> q.st.program_fail_flag)
    else $error("program fail not flagged");
  erase_fail_set_a: assert property (erase_fail |=> q.st.erase_fail_flag)
    else $error("erase fail not flagged");
  quad_pin_role_a: assert property (quad_pins_on |-> !pause_pin_on && !restart_pin_on)
    else $error("control pin active in quad mode");
  ext_ignored_a: assert property (addr_four_byte |-> !upper_half_select)
    else $error("extension bit used in four byte mode");
  array_clears_permit_a: assert property (array_cmd_valid |-> !write_permit_latch)
    else $error("permit latch left set after array command");

  word_write_cov: cover property (q.cfg_timer == flash_regs_pkg::CFG_WRITE_CYCLES);
  suspend_cov: cover property (suspend_req ##[1:1000] resume_req);
  array_cmd_cov: cover property (array_cmd_valid);
endmodule

// *** tb/flash_host_model.sv ***
// Host model that frames commands on the serial link
`timescale 1ns/10ps
module flash_host_model (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  // Link idle: clock stopped low, chip deselected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // One frame, MSB first, reply shifted in on rising edges
  task automatic xfer(input logic [31:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    cs_n = 1'b0;
    #20;
    for (int i = 0; i < n; i++) begin
      si = tx[31-i];
      #7.5 sclk = 1'b1;
      rx = {rx[6:0], so};
      #7.5 sclk = 1'b0;
    end
    #7.5 cs_n = 1'b1;
    si = ~si; // No stale data after the frame
    #100;
  endtask
endmodule

// *** tb/tb_flash_status_bank.sv ***
// Self-checking bench of the flash status and configuration bank
`timescale 1ns/10ps
module tb_flash_status_bank;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b1;
  logic wp_io_n = 1'b1;
  logic pause_restart_io_n = 1'b1;
  logic engine_busy = 1'b0;
  logic prog_fail = 1'b0;
  logic erase_fail = 1'b0;
  logic [23:0] nv_image = 24'h000000;
  logic sclk, cs_n, si, so, busy_flag, write_permit_latch, pause_pin_on, restart_pin_on;
  logic addr_four_byte, upper_half_select, nv_store_write;
  logic [23:0] nv_store_data;
  logic [7:0] array_cmd, rx;
  logic [3:0] dummy_cycles;
  logic [1:0] output_strength, secure_area_lock;
  logic [4:0] area_guard;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;

  // System clock
  always #2 sys_clk = ~sys_clk;

  flash_status_bank u_dut (
    .sys_clk, .reset_n, .sclk, .cs_n, .si, .so, .so_oe_n(), .wp_io_n,
    .pause_restart_io_n, .nv_image, .engine_busy, .prog_fail, .erase_fail,
    .array_cmd_valid(), .array_cmd, .suspend_req(), .resume_req(), .nv_store_write,
    .nv_store_data, .busy_flag, .write_permit_latch, .quad_pins_on(), .pause_pin_on,
    .restart_pin_on, .dummy_cycles, .output_strength, .addr_four_byte,
    .upper_half_select, .area_guard, .secure_area_lock
  );
  flash_host_model u_host (.sclk, .cs_n, .si, .so);

  // Non-volatile store and cycle ceiling
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (nv_store_write === 1'b1) begin
      nv_image <= nv_store_data;
    end
    if (cycles == 40000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic op(input logic [31:0] tx, input int n);
    u_host.xfer(tx, n, rx);
    @(negedge sys_clk);
  endtask

  // Word write after permit, then wait out the busy time
  task automatic wr(input logic [31:0] tx, input int n, input logic acc);
    op(32'h06000000, 8);
    op(tx, n);
    chk(busy_flag, acc);
    for (int i = 0; i < 2000 && busy_flag !== 1'b0; i++) @(negedge sys_clk);
    chk(busy_flag, 1'b0);
  endtask

  task automatic rst();
    reset_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic test_done();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    #1 reset_n = 1'b0; // A real falling edge also clears the link handover flops
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(addr_four_byte, 1'b0);
    chk(pause_pin_on, 1'b1);
    op(32'h017c0000, 16);
    chk(area_guard, 5'h00);
    wr(32'h017c0000, 16, 1'b1);
    chk(area_guard, 5'h1f);
    chk(write_permit_latch, 1'b0);
    op(32'h05000000, 16);
    chk(rx, 8'h7c);
    for (int c = 0; c < 4; c++) begin
      wr({8'h11, 1'b0, c[1:0], 3'h0, c[1:0], 16'h0000}, 16, 1'b1);
      chk(dummy_cycles, (c < 2) ? 4'h6 : (c == 2) ? 4'h8 : 4'ha);
      chk(output_strength, c[1:0]);
    end
    wr(32'h11f30000, 16, 1'b1);
    chk(addr_four_byte, 1'b0);
    chk(restart_pin_on, 1'b1);
    chk(pause_pin_on, 1'b0);
    // Guard modes 01 and 10
    wr(32'h01800000, 16, 1'b1);
    wp_io_n = 1'b0;
    wr(32'h01840000, 16, 1'b0);
    chk(area_guard, 5'h00);
    wp_io_n = 1'b1;
    wr(32'h01040000, 16, 1'b1);
    chk(area_guard, 5'h01);
    wr(32'h01040100, 24, 1'b1);
    wr(32'h01080000, 16, 1'b0);
    chk(area_guard, 5'h01);
    rst();
    chk(addr_four_byte, 1'b1);
    chk(dummy_cycles, 4'ha);
    wr(32'h01080000, 16, 1'b1);
    chk(area_guard, 5'h02);
    // Security lock bit set once, then a write of zero must not clear it
    wr(32'h01082000, 24, 1'b1);
    wr(32'h01080000, 24, 1'b1);
    chk(secure_area_lock, 2'h2);
    // Address width and extension bit
    op(32'hc5010000, 16);
    chk(upper_half_select, 1'b0);
    op(32'he9000000, 8);
    chk(addr_four_byte, 1'b0);
    op(32'hc5010000, 16);
    chk(upper_half_select, 1'b1);
    op(32'hb7000000, 8);
    chk(addr_four_byte, 1'b1);
    chk(upper_half_select, 1'b0);
    // Program, suspend, failure and resume
    op(32'h06000000, 8);
    op(32'h02000000, 8);
    chk(array_cmd, 8'h02);
    chk(write_permit_latch, 1'b0);
    engine_busy = 1'b1;
    op(32'h75000000, 8);
    op(32'h35000000, 16);
    chk(rx, 8'h2c);
    prog_fail = 1'b1;
    @(negedge sys_clk);
    prog_fail = 1'b0;
    op(32'h15000000, 16);
    chk(rx, 8'hf7);
    op(32'h7a000000, 8);
    op(32'h35000000, 16);
    chk(rx, 8'h28);
    op(32'h15000000, 16);
    chk(rx, 8'hf3);
    // Erase, failure, suspend and resume
    engine_busy = 1'b0;
    op(32'h06000000, 8);
    op(32'h20000000, 8);
    chk(array_cmd, 8'h20);
    chk(write_permit_latch, 1'b0);
    engine_busy = 1'b1;
    erase_fail = 1'b1;
    @(negedge sys_clk);
    erase_fail = 1'b0;
    op(32'h75000000, 8);
    op(32'h35000000, 16);
    chk(rx, 8'ha8);
    op(32'h15000000, 16);
    chk(rx, 8'hfb);
    op(32'h7a000000, 8);
    op(32'h15000000, 16);
    chk(rx, 8'hf3);
    engine_busy = 1'b0;
    test_done();
  end
endmodule
